// [dv/psq_pin_model.sv]
// Open-drain port pins with pull-ups and an outside driver
`timescale 1ns/100ps
module psq_pin_model
(
   input  wire logic [8:0] pinOe,
   input  wire logic [8:0] pinOut,
   input  wire logic [8:0] extLow,
   output logic      [8:0] pinIn
);
   // Released pin floats up unless the outside pulls it low
   assign pinIn = (pinOe & pinOut) | (~pinOe & ~extLow);
endmodule

// [dv/psq_props.sv]
// Port assertions for the program sequencer
`timescale 1ns/100ps
module psq_props
   import psq_pkg::*;
#(
   parameter bit LARGE = 1'b0
)
(
   input wire logic                 clock,
   input wire logic                 arst_n,
   input wire psq_pkg::psq_seq_op_t seqOp,
   input wire logic [10:0]          target,
   input wire logic [1:0]           tablePage,
   input wire logic [6:0]           tableWord,
   input wire logic [10:0]          intVector,
   input wire psq_pkg::psq_ptr_op_t ptrOp,
   input wire logic [6:0]           ptrValue,
   input wire psq_pkg::psq_bit_op_t bitOp,
   input wire logic [10:0]          instrAddr,
   input wire logic [6:0]           ramPointer,
   input wire logic [2:0]           stackLevel,
   input wire logic                 stackOverflow,
   input wire logic                 inInterrupt,
   input wire logic                 carryRestore,
   input wire logic [8:0]           pinOe
);
   localparam logic [10:0] PCM = LARGE ? 11'h7ff : 11'h3ff;
   localparam logic [1:0]  TPG = LARGE ? 2'h3 : 2'h1;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   property p_next;
      seqOp == SEQ_NEXT |=> instrAddr == (($past(instrAddr) + 11'h1) & PCM);
   endproperty
   a_next: assert property (p_next) else $error("sequential step wrong");
   property p_jump;
      seqOp == SEQ_JUMP |=> instrAddr == ($past(target) & PCM);
   endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong");
   property p_page2;
      seqOp == SEQ_PAGE2 && stackLevel < 3'h4 |=> instrAddr == {4'h2, $past(target[6:0])};
   endproperty
   a_page2: assert property (p_page2) else $error("page 2 call wrong");
   property p_tab;
      seqOp == SEQ_TAB && stackLevel < 3'h4 |=>
         instrAddr == {TPG, $past(tablePage), $past(tableWord)} &&
         stackLevel == $past(stackLevel) + 3'h1;
   endproperty
   a_tab: assert property (p_tab) else $error("table fetch wrong");
   property p_callret;
      seqOp == SEQ_CALL && stackLevel < 3'h4 ##1 seqOp == SEQ_RET |=>
         instrAddr == (($past(instrAddr, 2) + 11'h1) & PCM);
   endproperty
   a_callret: assert property (p_callret) else $error("return address wrong");
   property p_full;
      seqOp == SEQ_CALL && stackLevel == 3'h4 |=> stackOverflow && stackLevel == 3'h4;
   endproperty
   a_full: assert property (p_full) else $error("full stack not refused");
   property p_intr;
      seqOp == SEQ_INTR && stackLevel < 3'h4 |=>
         instrAddr == ($past(intVector) & PCM) && inInterrupt;
   endproperty
   a_intr: assert property (p_intr) else $error("interrupt entry wrong");
   property p_reti;
      seqOp == SEQ_RETI && stackLevel != 3'h0 |=> carryRestore && !inInterrupt;
   endproperty
   a_reti: assert property (p_reti) else $error("interrupt return wrong");
   property p_reset;
      $rose(arst_n) |-> instrAddr == 11'h000 && stackLevel == 3'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_ptr;
      ptrOp == PTR_LOAD && seqOp != SEQ_RETI |=> ramPointer == $past(ptrValue);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer load wrong");
   property p_pin;
      bitOp == PIN_CLEAR && ramPointer[3:0] < 4'h9 |=> pinOe[$past(ramPointer[3:0])];
   endproperty
   a_pin: assert property (p_pin) else $error("pin latch not cleared");
endmodule

bind psq_sequencer psq_props #(.LARGE(LARGE)) u_props (.clock(clock), .arst_n(arst_n),
   .seqOp(seqOp), .target(target), .tablePage(tablePage), .tableWord(tableWord),
   .intVector(intVector), .ptrOp(ptrOp), .ptrValue(ptrValue), .bitOp(bitOp),
   .instrAddr(instrAddr), .ramPointer(ramPointer), .stackLevel(stackLevel),
   .stackOverflow(stackOverflow), .inInterrupt(inInterrupt),
   .carryRestore(carryRestore), .pinOe(pinOe));

// [dv/tb_top.sv]
// Self-checking bench for the program sequencer
`timescale 1ns/100ps
module tb_top;
   import psq_pkg::*;
   logic          clock, arst_n, carryIn, ramWe, bitResult, carryOut, carryRestore;
   logic          stackOverflow, inInterrupt;
   psq_seq_op_t   seqOp;
   psq_ptr_op_t   ptrOp;
   psq_bit_op_t   bitOp;
   logic [10:0]   target, intVector, instrAddr, pc0;
   logic [10:0]   saved [4];
   logic [6:0]    tableWord, ptrValue, ramPointer;
   logic [1:0]    tablePage, bitSel;
   logic [3:0]    ramWdata, ramRdata;
   logic [8:0]    pinIn, pinOut, pinOe, extLow;
   logic [2:0]    stackLevel;
   logic [10:0]   instrAddrL;
   logic [3:0]    ramRdataL;
   int            fails, compares;

   psq_sequencer #(.LARGE(1'b0)) DUT (.clock(clock), .arst_n(arst_n), .seqOp(seqOp),
      .target(target), .tablePage(tablePage), .tableWord(tableWord),
      .intVector(intVector), .ptrOp(ptrOp), .ptrValue(ptrValue), .carryIn(carryIn),
      .bitOp(bitOp), .bitSel(bitSel), .ramWe(ramWe), .ramWdata(ramWdata),
      .pinIn(pinIn), .instrAddr(instrAddr), .ramPointer(ramPointer),
      .ramRdata(ramRdata), .bitResult(bitResult), .carryOut(carryOut),
      .carryRestore(carryRestore), .stackLevel(stackLevel),
      .stackOverflow(stackOverflow), .inInterrupt(inInterrupt), .pinOut(pinOut),
      .pinOe(pinOe));
   // Larger variant runs the same stimulus; only its addresses and data are compared
   psq_sequencer #(.LARGE(1'b1)) DUT_L (.clock(clock), .arst_n(arst_n), .seqOp(seqOp),
      .target(target), .tablePage(tablePage), .tableWord(tableWord),
      .intVector(intVector), .ptrOp(ptrOp), .ptrValue(ptrValue), .carryIn(carryIn),
      .bitOp(bitOp), .bitSel(bitSel), .ramWe(ramWe), .ramWdata(ramWdata),
      .pinIn(pinIn), .instrAddr(instrAddrL), .ramPointer(), .ramRdata(ramRdataL),
      .bitResult(), .carryOut(), .carryRestore(), .stackLevel(),
      .stackOverflow(), .inInterrupt(), .pinOut(), .pinOe());
   psq_pin_model PM (.pinOe(pinOe), .pinOut(pinOut), .extLow(extLow), .pinIn(pinIn));

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Inputs move 10 ns after the edge so the design never races the bench
   task automatic cyc(input int n = 1);
      repeat (n)
      begin
         @(posedge clock);
         #10;
         seqOp = SEQ_HOLD;
         ptrOp = PTR_KEEP;
         bitOp = BIT_NONE;
         ramWe = 1'b0;
      end
   endtask

   task automatic sq(input psq_seq_op_t o, input logic [10:0] t);
      seqOp = o;
      target = t;
      cyc();
   endtask

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial
   begin
      {arst_n, carryIn, ramWe, target, intVector, tableWord, tablePage} = '0;
      {ptrValue, bitSel, ramWdata, extLow} = '0;
      seqOp = SEQ_HOLD;
      ptrOp = PTR_KEEP;
      bitOp = BIT_NONE;
      repeat (8) @(posedge clock);
      #10;
      arst_n = 1'b1;
      chk(instrAddr, 11'h000);
      chk(stackLevel, 11'h0);
      chk(pinOe, 9'h000);
      sq(SEQ_JUMP, 11'h07e);
      sq(SEQ_NEXT, 11'h0);
      sq(SEQ_NEXT, 11'h0);
      chk(instrAddr, 11'h080);
      sq(SEQ_JUMP, 11'h3ff);
      sq(SEQ_NEXT, 11'h0);
      chk(instrAddr, 11'h000);
      chk(instrAddrL, 11'h400);
      sq(SEQ_JUMP, 11'h7ff);
      sq(SEQ_NEXT, 11'h0);
      chk(instrAddrL, 11'h000);
      pc0 = 11'h000;
      for (int i = 0; i < 4; i++)
      begin
         saved[i] = pc0 + 11'h1;
         pc0 = 11'h105 + 11'(i);
         sq(SEQ_CALL, pc0);
         chk(instrAddr, pc0);
         chk(stackLevel, 11'(i + 1));
      end
      sq(SEQ_CALL, 11'h300);
      chk(stackLevel, 11'h4);
      chk(stackOverflow, 11'h1);
      for (int i = 3; i >= 0; i--)
      begin
         sq(SEQ_RET, 11'h0);
         chk(instrAddr, saved[i]);
      end
      sq(SEQ_RET, 11'h0);
      chk(instrAddr, saved[0]);
      chk(stackLevel, 11'h0);
      sq(SEQ_JUMP, 11'h283);
      sq(SEQ_PAGE2, 11'h015);
      chk(instrAddr, 11'h115);
      sq(SEQ_RET, 11'h0);
      chk(instrAddr, 11'h284);
      for (int p = 0; p < 4; p++)
      begin
         tablePage = 2'(p);
         tableWord = 7'h09;
         sq(SEQ_TAB, 11'h0);
         chk(instrAddr, {4'h4 + 4'(p), 7'h09});
         chk(instrAddrL, {4'hc + 4'(p), 7'h09});
         chk(stackLevel, 11'h1);
         sq(SEQ_TAB_END, 11'h0);
         chk(instrAddr, 11'h285 + 11'(p));
      end
      // The pointer must stand before entry, since entry saves the current one
      ptrOp = PTR_LOAD;
      ptrValue = 7'h5a;
      cyc();
      carryIn = 1'b1;
      intVector = 11'h084;
      sq(SEQ_INTR, 11'h0);
      chk(instrAddr, 11'h084);
      chk(inInterrupt, 11'h1);
      chk(stackLevel, 11'h1);
      ptrOp = PTR_LOAD;
      ptrValue = 7'h13;
      carryIn = 1'b0;
      cyc();
      chk(ramPointer, 11'h13);
      sq(SEQ_RETI, 11'h0);
      chk(instrAddr, 11'h288);
      chk(ramPointer, 11'h5a);
      chk(carryOut, 11'h1);
      chk(carryRestore, 11'h1);
      chk(inInterrupt, 11'h0);
      cyc();
      chk(carryRestore, 11'h0);
      ptrOp = PTR_LOAD;
      ptrValue = 7'h2f;
      cyc();
      ptrOp = PTR_INC;
      cyc();
      chk(ramPointer, 11'h20);
      ptrOp = PTR_DEC;
      cyc();
      chk(ramPointer, 11'h2f);
      ptrOp = PTR_LOAD;
      ptrValue = 7'h35;
      cyc();
      for (int k = 0; k < 4; k++)
      begin
         bitOp = BIT_SET;
         bitSel = 2'(k);
         cyc();
         chk(ramRdata, 11'(1 << k));
         bitOp = BIT_TEST;
         cyc();
         chk(bitResult, 11'h1);
         bitOp = BIT_CLEAR;
         cyc();
         chk(ramRdata, 11'h0);
         bitOp = BIT_TEST;
         cyc();
         chk(bitResult, 11'h0);
      end
      // Digit 13 aliases digit 5 in the base variant only
      ptrOp = PTR_LOAD;
      ptrValue = 7'h3d;
      cyc();
      ramWe = 1'b1;
      ramWdata = 4'ha;
      cyc();
      chk(ramRdata, 11'ha);
      chk(ramRdataL, 11'ha);
      ptrOp = PTR_LOAD;
      ptrValue = 7'h35;
      cyc();
      chk(ramRdata, 11'ha);
      chk(ramRdataL, 11'h0);
      // Digit nine names no pin and must leave every pin alone
      for (int d = 0; d < 10; d++)
      begin
         ptrOp = PTR_LOAD;
         ptrValue = 7'(d);
         cyc();
         bitOp = PIN_CLEAR;
         cyc();
         chk(pinOe, d < 9 ? 11'h1 << d : 11'h0);
         bitOp = PIN_SET;
         extLow = 9'h1ff;
         cyc(3);
         bitOp = PIN_TEST;
         cyc();
         chk(bitResult, 11'h0);
         extLow = 9'h000;
         cyc(2);
         bitOp = PIN_TEST;
         cyc();
         chk(bitResult, 11'(d < 9));
      end
      sq(SEQ_JUMP, 11'h4a0);
      sq(SEQ_CALL, 11'h011);
      sq(SEQ_RET, 11'h0);
      chk(instrAddr, 11'h0a1);
      chk(instrAddrL, 11'h4a1);
      chk(stackOverflow, 11'h1);
      sq(SEQ_CALL, 11'h011);
      arst_n = 1'b0;
      cyc(2);
      arst_n = 1'b1;
      cyc();
      chk(instrAddr, 11'h000);
      chk(stackLevel, 11'h0);
      chk(stackOverflow, 11'h0);
      conclude();
   end

   initial
   begin
      repeat (3000) @(posedge clock);
      fails++;
      $display("Error at %0t: timeout", $time);
      conclude();
   end
endmodule

// [hw/psq_pkg.sv]
// Shared constants and encodings of the program sequencer and RAM pointer
package psq_pkg;

   // -----------------------------------------------------------------
   // Program memory layout
   // -----------------------------------------------------------------
   localparam int            WORD_W          = 7;
   localparam int            PAGE_W_BASE     = 3;
   localparam int            PAGE_W_LARGE    = 4;
   localparam int            STACK_DEPTH     = 4;
   localparam int            SP_W            = 3;
   localparam logic [3:0]    SUB_PAGE        = 4'h2;
   localparam logic [3:0]    TAB_PAGE_BASE   = 4'h4;
   localparam logic [3:0]    TAB_PAGE_LARGE  = 4'hc;
   localparam logic [10:0]   PC_RESET        = 11'h000;

   // -----------------------------------------------------------------
   // Data pointer and data memory layout
   // -----------------------------------------------------------------
   localparam int            DIGIT_W         = 4;
   localparam int            FILE_W          = 2;
   localparam int            GROUP_W         = 1;
   localparam int            PTR_W           = 7;
   localparam int            DATA_W          = 4;
   localparam int            DIGITS_BASE     = 8;
   localparam int            DIGITS_LARGE    = 16;
   localparam logic [6:0]    PTR_RESET       = 7'h00;
   localparam int            PORT_PINS       = 9;
   localparam logic [8:0]    PORT_RESET      = 9'h1ff;

   // -----------------------------------------------------------------
   // Sequencer operations
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      SEQ_HOLD     = 4'h0,
      SEQ_NEXT     = 4'h1,
      SEQ_JUMP     = 4'h2,
      SEQ_CALL     = 4'h3,
      SEQ_PAGE2    = 4'h4,
      SEQ_TAB      = 4'h5,
      SEQ_TAB_END  = 4'h6,
      SEQ_RET      = 4'h7,
      SEQ_RETI     = 4'h8,
      SEQ_INTR     = 4'h9
   } psq_seq_op_t;

   // -----------------------------------------------------------------
   // Bit operations on data memory and the single-bit port
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      BIT_NONE     = 3'h0,
      BIT_SET      = 3'h1,
      BIT_CLEAR    = 3'h2,
      BIT_TEST     = 3'h3,
      PIN_SET      = 3'h4,
      PIN_CLEAR    = 3'h5,
      PIN_TEST     = 3'h6
   } psq_bit_op_t;

   typedef enum logic [1:0] {
      PTR_KEEP     = 2'h0,
      PTR_LOAD     = 2'h1,
      PTR_INC      = 2'h2,
      PTR_DEC      = 2'h3
   } psq_ptr_op_t;

endpackage

// [hw/psq_sequencer.sv]
// Program sequencer, return stack, data pointer, data memory and single-bit port
`timescale 1ns/100ps

module psq_sequencer
  import psq_pkg::*;
#(
   parameter bit LARGE = 1'b0
)
(
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   input  wire psq_pkg::psq_seq_op_t seqOp,
   input  wire logic [10:0]          target,
   input  wire logic [1:0]           tablePage,
   input  wire logic [6:0]           tableWord,
   input  wire logic [10:0]          intVector,
   input  wire psq_pkg::psq_ptr_op_t ptrOp,
   input  wire logic [6:0]           ptrValue,
   input  wire logic                 carryIn,
   input  wire psq_pkg::psq_bit_op_t bitOp,
   input  wire logic [1:0]           bitSel,
   input  wire logic                 ramWe,
   input  wire logic [3:0]           ramWdata,
   input  wire logic [8:0]           pinIn,
   output logic [10:0]               instrAddr,
   output logic [6:0]                ramPointer,
   output logic [3:0]                ramRdata,
   output logic                      bitResult,
   output logic                      carryOut,
   output logic                      carryRestore,
   output logic [2:0]                stackLevel,
   output logic                      stackOverflow,
   output logic                      inInterrupt,
   output logic [8:0]                pinOut,
   output logic [8:0]                pinOe
);
   import psq_pkg::*;

   // -----------------------------------------------------------------
   // Derived geometry
   // -----------------------------------------------------------------
   localparam int            PAGE_W   = LARGE ? PAGE_W_LARGE : PAGE_W_BASE;
   localparam int            PC_W     = PAGE_W + WORD_W;
   localparam int            DIGITS   = LARGE ? DIGITS_LARGE : DIGITS_BASE;
   localparam int            RAM_WDS  = DIGITS * (1 << (FILE_W + GROUP_W));
   localparam int            RADDR_W  = $clog2(RAM_WDS);
   localparam logic [3:0]    TAB_BASE = LARGE ? TAB_PAGE_LARGE : TAB_PAGE_BASE;

   typedef struct packed {
      logic [PC_W-1:0]                         pc;
      logic [STACK_DEPTH-1:0][PC_W-1:0]        slots;
      logic [SP_W-1:0]                         sp;
      logic                                    overflow;
      logic [PTR_W-1:0]                        ptr;
      logic [PTR_W-1:0]                        ptrSave;
      logic                                    carrySave;
      logic                                    carryOut;
      logic                                    carryRestore;
      logic                                    inIntr;
      logic [RAM_WDS-1:0][DATA_W-1:0]          ram;
      logic [PORT_PINS-1:0]                    latch;
      logic [PORT_PINS-1:0]                    sync1;
      logic [PORT_PINS-1:0]                    sync2;
      logic                                    bitRes;
   } psq_state_t;

   psq_state_t st_r;
   psq_state_t st_nxt;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Base variant ignores the top digit bit for data memory: only 8 digits exist
   function automatic logic [RADDR_W-1:0] ramIndex(input logic [PTR_W-1:0] p);
      logic [RADDR_W-1:0] idx;
      if (LARGE)
         idx = RADDR_W'(p);
      else
         idx = RADDR_W'({p[PTR_W-1:DIGIT_W], p[DIGIT_W-2:0]});
      return idx;
   endfunction

   function automatic logic [PC_W-1:0] pageWord(input logic [3:0] page,
                                                input logic [6:0] word);
      return PC_W'({page[PAGE_W-1:0], word});
   endfunction

   // Digits nine to fifteen name no port pin
   function automatic logic pinValid(input logic [3:0] d);
      return d < 4'(PORT_PINS);
   endfunction

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb
   begin
      logic [PC_W-1:0]    incPc;
      logic [PC_W-1:0]    pushVal;
      logic [PC_W-1:0]    loadVal;
      logic               doPush;
      logic               doPop;
      logic [RADDR_W-1:0] ri;
      logic [3:0]         digit;
      logic [3:0]         tabPage;
      incPc   = st_r.pc + PC_W'(1);
      pushVal = incPc;
      loadVal = incPc;
      doPush  = 1'b0;
      doPop   = 1'b0;
      tabPage = TAB_BASE | {2'b00, tablePage};
      ri      = ramIndex(st_r.ptr);
      digit   = st_r.ptr[DIGIT_W-1:0];
      st_nxt  = st_r;
      st_nxt.carryRestore = 1'b0;

      // -----------------------------------------------------------------
      // Pin synchroniser
      // -----------------------------------------------------------------
      // Pins move at any time, so only the second flop feeds the pin test
      st_nxt.sync1 = pinIn;
      st_nxt.sync2 = st_r.sync1;

      // -----------------------------------------------------------------
      // Instruction pointer operations
      // -----------------------------------------------------------------
      unique case (seqOp)
         SEQ_HOLD:    loadVal = st_r.pc;
         SEQ_NEXT:    loadVal = incPc;
         SEQ_JUMP:    loadVal = target[PC_W-1:0];
         SEQ_CALL:
         begin
            doPush  = 1'b1;
            loadVal = target[PC_W-1:0];
         end
         SEQ_PAGE2:
         begin
            doPush  = 1'b1;
            loadVal = pageWord(SUB_PAGE, target[WORD_W-1:0]);
         end
         SEQ_TAB:
         begin
            doPush  = 1'b1;
            loadVal = pageWord(tabPage, tableWord);
         end
         SEQ_TAB_END, SEQ_RET:
         begin
            doPop   = 1'b1;
         end
         SEQ_RETI:
         begin
            doPop   = 1'b1;
            st_nxt.ptr          = st_r.ptrSave;
            st_nxt.carryOut     = st_r.carrySave;
            st_nxt.carryRestore = 1'b1;
            st_nxt.inIntr       = 1'b0;
         end
         SEQ_INTR:
         begin
            // The interrupted instruction has not run, so its own address returns
            doPush  = 1'b1;
            pushVal = st_r.pc;
            loadVal = intVector[PC_W-1:0];
            st_nxt.ptrSave   = st_r.ptr;
            st_nxt.carrySave = carryIn;
            st_nxt.inIntr    = 1'b1;
         end
         default:     loadVal = st_r.pc;
      endcase

      // -----------------------------------------------------------------
      // Return stack
      // -----------------------------------------------------------------
      // A push beyond the fourth slot is dropped and flagged rather than wrapped
      // A pop on an empty stack keeps the pointer where it is
      if (doPush)
      begin
         if (st_r.sp < SP_W'(STACK_DEPTH))
         begin
            st_nxt.slots[st_r.sp[1:0]] = pushVal;
            st_nxt.sp = st_r.sp + SP_W'(1);
         end
         else
            st_nxt.overflow = 1'b1;
      end
      if (doPop)
      begin
         if (st_r.sp != '0)
         begin
            loadVal   = st_r.slots[st_r.sp[1:0] - 2'h1];
            st_nxt.sp = st_r.sp - SP_W'(1);
         end
         else
            loadVal = st_r.pc;
      end
      st_nxt.pc = loadVal;

      // -----------------------------------------------------------------
      // Data pointer
      // -----------------------------------------------------------------
      // Restore on interrupt return takes precedence over the pointer operation
      // Digit steps wrap inside the digit field; group and file stay put
      if (seqOp != SEQ_RETI)
      begin
         unique case (ptrOp)
            PTR_KEEP: st_nxt.ptr = st_r.ptr;
            PTR_LOAD: st_nxt.ptr = ptrValue;
            PTR_INC:  st_nxt.ptr[DIGIT_W-1:0] = st_r.ptr[DIGIT_W-1:0] + 4'h1;
            PTR_DEC:  st_nxt.ptr[DIGIT_W-1:0] = st_r.ptr[DIGIT_W-1:0] - 4'h1;
            default:  st_nxt.ptr = st_r.ptr;
         endcase
      end

      // -----------------------------------------------------------------
      // Data memory and single-bit port
      // -----------------------------------------------------------------
      // A same-cycle bit operation overrides the written word in its bit
      if (ramWe)
         st_nxt.ram[ri] = ramWdata;
      unique case (bitOp)
         BIT_NONE:  st_nxt.bitRes = st_r.bitRes;
         BIT_SET:   st_nxt.ram[ri][bitSel] = 1'b1;
         BIT_CLEAR: st_nxt.ram[ri][bitSel] = 1'b0;
         BIT_TEST:  st_nxt.bitRes = st_r.ram[ri][bitSel];
         PIN_SET:
         begin
            if (pinValid(digit))
               st_nxt.latch[digit] = 1'b1;
         end
         PIN_CLEAR:
         begin
            if (pinValid(digit))
               st_nxt.latch[digit] = 1'b0;
         end
         PIN_TEST:
         begin
            // A cleared latch pulls the pin low, so the test then reads 0
            if (pinValid(digit))
               st_nxt.bitRes = st_r.sync2[digit] & st_r.latch[digit];
            else
               st_nxt.bitRes = 1'b0;
         end
         default:   st_nxt.bitRes = st_r.bitRes;
      endcase
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r           <= '0;
         st_r.pc        <= PC_RESET[PC_W-1:0];
         st_r.sp        <= '0;
         st_r.ptr       <= PTR_RESET;
         st_r.ptrSave   <= PTR_RESET;
         st_r.latch     <= PORT_RESET;
      end
      else
         st_r <= st_nxt;
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign instrAddr     = 11'(st_r.pc);
   assign ramPointer    = st_r.ptr;
   assign ramRdata      = st_r.ram[ramIndex(st_r.ptr)];
   assign bitResult     = st_r.bitRes;
   assign carryOut      = st_r.carryOut;
   assign carryRestore  = st_r.carryRestore;
   assign stackLevel    = st_r.sp;
   assign stackOverflow = st_r.overflow;
   assign inInterrupt   = st_r.inIntr;
   // Open drain: drive low only where the latch holds 0
   assign pinOut        = '0;
   assign pinOe         = ~st_r.latch;

endmodule
